/* rtl/ipfc_pkg.sv */
package ipfc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PWM_FREQ_HZ = 100_000;
  localparam int unsigned TICK_MS = 1;
  // half period of the up/down counter, in clock cycles
  localparam int unsigned HALF_CYC = CLK_HZ / PWM_FREQ_HZ / 2;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DW = 16;
  localparam logic [DW-1:0] PERIOD_TOP = DW'(HALF_CYC);
  localparam logic [DW-1:0] DUTY_RST = 16'h0000;
  localparam logic [7:0] CROSSBAR_SEL_RST = 8'h01;
  localparam int unsigned FAULT_W = 6;
  localparam int unsigned FLT_IN_UV = 0;
  localparam int unsigned FLT_IN_OV = 1;
  localparam int unsigned FLT_BUS_UV = 2;
  localparam int unsigned FLT_BUS_OV = 3;
  localparam int unsigned FLT_OC = 4;
  localparam int unsigned FLT_START = 5;
endpackage

/* rtl/ipfc_top.sv */
// Operation
// - one modulator drives two phase outputs
// - up/down counter gives center-aligned pulses
// - fixed 100 kHz period, duty varies only
// - phase b lags half a period
// - reload event every second period
// - current loops run on reload
// - one mid-period trigger per phase
// - triggers routed via configurable crossbar
// - periodic tick timer every 1 ms
// - voltage error is reference minus bus, floored at zero
// - current reference from vctrl, vin, feed-forward
// - per-phase current error sets duty
// - six fault flags detected
`timescale 1ns/1ps
module ipfc_top
  import ipfc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = ipfc_pkg::TICK_CYC
)(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [ipfc_pkg::DW-1:0] vin_meas,
  input wire logic [ipfc_pkg::DW-1:0] vbus_meas,
  input wire logic [ipfc_pkg::DW-1:0] ia_meas,
  input wire logic [ipfc_pkg::DW-1:0] ib_meas,
  input wire logic [ipfc_pkg::DW-1:0] vbus_ref,
  input wire logic [ipfc_pkg::DW-1:0] ff_factor,
  input wire logic [ipfc_pkg::DW-1:0] vin_uv_lim,
  input wire logic [ipfc_pkg::DW-1:0] vin_ov_lim,
  input wire logic [ipfc_pkg::DW-1:0] vbus_uv_lim,
  input wire logic [ipfc_pkg::DW-1:0] vbus_ov_lim,
  input wire logic [ipfc_pkg::DW-1:0] i_oc_lim,
  input wire logic [ipfc_pkg::DW-1:0] kp_v,
  input wire logic [ipfc_pkg::DW-1:0] kp_i,
  input wire logic run_en,
  input wire logic startup_fail,
  input wire logic fault_clear,
  input wire logic [7:0] signal_crossbar_sel,
  output logic drive_a,
  output logic drive_b,
  output logic [7:0] adc_trig,
  output logic reload_evt,
  output logic periodic_tick_timer,
  output logic [ipfc_pkg::FAULT_W-1:0] fault_flags,
  output logic [ipfc_pkg::DW-1:0] duty_a,
  output logic [ipfc_pkg::DW-1:0] duty_b
);
  import ipfc_pkg::*;

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic dn;
    logic per_par;
    logic [31:0] tick_cnt;
    logic [DW-1:0] verr;
    logic [DW-1:0] iref;
    logic [DW-1:0] da;
    logic [DW-1:0] db;
    logic [DW-1:0] ca;
    logic [DW-1:0] cb;
    logic [FAULT_W-1:0] flt;
    logic [1:0] sync_fc;
    logic [1:0] sync_sf;
    logic oa;
    logic ob;
    logic [7:0] trig;
    logic rel;
    logic tick;
  } ipfc_st_t;

  ipfc_st_t s_q, s_d;

  function automatic logic [DW-1:0] clamp_duty(input logic signed [2*DW+1:0] v);
    if (v < 0)
      return '0;
    else if (v > $signed({{(DW+2){1'b0}}, PERIOD_TOP}))
      return PERIOD_TOP;
    else
      return v[DW-1:0];
  endfunction

  logic signed [2*DW+1:0] prod_v, prod_i, err_a, err_b;
  logic mid_a, mid_b, per_end;

  always_comb
  begin
    s_d = s_q;
    s_d.rel = 1'b0;
    s_d.tick = 1'b0;
    s_d.trig = '0;
    s_d.sync_fc = {s_q.sync_fc[0], fault_clear};
    s_d.sync_sf = {s_q.sync_sf[0], startup_fail};
    // up/down center-aligned counter, one period = 2*PERIOD_TOP
    mid_a = !s_q.dn && s_q.cnt == PERIOD_TOP - 16'h0001;
    mid_b = s_q.dn && s_q.cnt == 16'h0001;
    per_end = mid_b;
    if (!s_q.dn)
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
      if (s_q.cnt == PERIOD_TOP - 16'h0001)
        s_d.dn = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt - 16'h0001;
      if (s_q.cnt == 16'h0001)
        s_d.dn = 1'b0;
    end
    // trigger per phase at its own period midpoint, through crossbar
    for (int k = 0; k < 4; k++)
    begin
      if (mid_a && signal_crossbar_sel[2*k])
        s_d.trig[2*k] = 1'b1;
      if (mid_b && signal_crossbar_sel[2*k+1])
        s_d.trig[2*k+1] = 1'b1;
    end
    if (per_end)
    begin
      s_d.per_par = !s_q.per_par;
      s_d.rel = s_q.per_par;
    end
    // slow loop: voltage error and shared current reference
    if (s_q.tick_cnt >= TICK_CYCLES - 1)
    begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.tick_cnt = s_q.tick_cnt + 32'h0000_0001;
    prod_v = $signed({2'b00, kp_v}) * $signed({2'b00, s_q.verr}) >>> DW;
    prod_i = $signed({2'b00, prod_v[DW-1:0]}) * $signed({2'b00, vin_meas}) >>> DW;
    prod_i = $signed({2'b00, prod_i[DW-1:0]}) * $signed({2'b00, ff_factor}) >>> DW;
    if (s_q.tick)
    begin
      s_d.verr = (vbus_ref > vbus_meas) ? vbus_ref - vbus_meas : '0;
      s_d.iref = prod_i[DW-1:0];
    end
    err_a = ($signed({{(DW+2){1'b0}}, s_q.iref}) - $signed({{(DW+2){1'b0}}, ia_meas}));
    err_b = ($signed({{(DW+2){1'b0}}, s_q.iref}) - $signed({{(DW+2){1'b0}}, ib_meas}));
    // phase_a_current_diff / phase_b_current_diff through P controllers
    if (s_q.rel)
    begin
      s_d.ca = clamp_duty((err_a * $signed({{(DW+2){1'b0}}, kp_i})) >>> DW);
      s_d.cb = clamp_duty((err_b * $signed({{(DW+2){1'b0}}, kp_i})) >>> DW);
    end
    // each phase loads while its own pulse is low, so no pulse is cut unevenly
    if (mid_a)
      s_d.da = s_q.ca;
    if (per_end)
      s_d.db = s_q.cb;
    // faults are sticky; new events win over clear
    if (s_q.sync_fc[1])
      s_d.flt = '0;
    if (vin_meas < vin_uv_lim) s_d.flt[FLT_IN_UV] = 1'b1;
    if (vin_meas > vin_ov_lim) s_d.flt[FLT_IN_OV] = 1'b1;
    if (vbus_meas < vbus_uv_lim) s_d.flt[FLT_BUS_UV] = 1'b1;
    if (vbus_meas > vbus_ov_lim) s_d.flt[FLT_BUS_OV] = 1'b1;
    if (ia_meas > i_oc_lim || ib_meas > i_oc_lim) s_d.flt[FLT_OC] = 1'b1;
    if (s_q.sync_sf[1]) s_d.flt[FLT_START] = 1'b1;
    // phase b compares the mirrored counter: half period shifted
    s_d.oa = run_en && s_q.flt == '0 && s_d.cnt < s_q.da;
    s_d.ob = run_en && s_q.flt == '0 && (PERIOD_TOP - s_d.cnt) < s_q.db;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign drive_a = s_q.oa;
  assign drive_b = s_q.ob;
  assign adc_trig = s_q.trig;
  assign reload_evt = s_q.rel;
  assign periodic_tick_timer = s_q.tick;
  assign fault_flags = s_q.flt;
  assign duty_a = s_q.da;
  assign duty_b = s_q.db;

  // reload every second period; checked here only as a one-cycle pulse followed by 8 idle cycles
  a_reload_spacing: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(reload_evt) |-> ##1 !reload_evt [*8])
    else $error("reload pulse too long");
  a_fault_blocks: assert property (@(posedge core_clk) disable iff (!reset_n)
    fault_flags != '0 |=> !drive_a && !drive_b)
    else $error("drive active during fault");
  a_trig_mid: assert property (@(posedge core_clk) disable iff (!reset_n)
    adc_trig[0] |-> $past(s_q.cnt) == PERIOD_TOP - 16'h0001)
    else $error("trigger a off midpoint");
  a_duty_clamp: assert property (@(posedge core_clk) disable iff (!reset_n)
    duty_a <= PERIOD_TOP && duty_b <= PERIOD_TOP)
    else $error("duty above period");
  a_tick_one: assert property (@(posedge core_clk) disable iff (!reset_n)
    periodic_tick_timer |=> !periodic_tick_timer)
    else $error("tick longer than one cycle");
  a_cnt_range: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_q.cnt <= PERIOD_TOP)
    else $error("counter out of range");
  a_phase_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
    !s_q.dn && s_q.cnt == PERIOD_TOP / 2 - 16'h0001 && s_q.da == s_q.db && run_en && fault_flags == '0
    |=> drive_a == drive_b)
    else $error("phases not half period apart");
  a_cross_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    adc_trig[1] |-> $past(signal_crossbar_sel[1]))
    else $error("crossbar routed disabled trigger");
  c_reload: cover property (@(posedge core_clk) disable iff (!reset_n) reload_evt);
  c_fault: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(fault_flags[FLT_OC]));
  c_drive: cover property (@(posedge core_clk) disable iff (!reset_n) drive_a && drive_b);
  c_tick: cover property (@(posedge core_clk) disable iff (!reset_n) periodic_tick_timer);
  c_clear: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(|fault_flags));
endmodule

/* verif/ipfc_adc_model.sv */
`timescale 1ns/1ps
module ipfc_adc_model
  import ipfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] adc_trig,
  input wire logic [ipfc_pkg::DW-1:0] vin_set,
  input wire logic [ipfc_pkg::DW-1:0] vbus_set,
  input wire logic [ipfc_pkg::DW-1:0] ia_set,
  input wire logic [ipfc_pkg::DW-1:0] ib_set,
  output logic [ipfc_pkg::DW-1:0] vin_meas,
  output logic [ipfc_pkg::DW-1:0] vbus_meas,
  output logic [ipfc_pkg::DW-1:0] ia_meas,
  output logic [ipfc_pkg::DW-1:0] ib_meas
);
  // all four channels converted on any trigger
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      {vin_meas, vbus_meas, ia_meas, ib_meas} <= '0;
    else if (|adc_trig)
      {vin_meas, vbus_meas, ia_meas, ib_meas} <= {vin_set, vbus_set, ia_set, ib_set};
  end
endmodule

/* verif/ipfc_top_bench.sv */
`timescale 1ns/1ps
module ipfc_top_bench;
  import ipfc_pkg::*;
  logic core_clk = 0, reset_n = 0, run_en = 0, sfail = 0, fclr = 0;
  logic [7:0] sel = 8'h03, trig;
  logic [15:0] vin_s = 16'h4000, vbus_s = 16'h1000, ia_s = 16'h0100, ib_s = 16'h0000;
  logic [15:0] uvl = 16'h0000, ovl = 16'hffff, bul = 16'h0000, bol = 16'hffff, ocl = 16'hffff;
  logic [15:0] vin, vbus, ia, ib, da, db;
  logic da_o, db_o, rel, tick;
  logic [5:0] flt;
  int miscompares = 0, checks_done = 0;
  ipfc_adc_model adc (.core_clk(core_clk), .reset_n(reset_n), .adc_trig(trig), .vin_set(vin_s),
    .vbus_set(vbus_s), .ia_set(ia_s), .ib_set(ib_s), .vin_meas(vin), .vbus_meas(vbus), .ia_meas(ia),
    .ib_meas(ib));
  ipfc_top #(.TICK_CYCLES(200)) uut (.core_clk(core_clk), .reset_n(reset_n), .vin_meas(vin),
    .vbus_meas(vbus), .ia_meas(ia), .ib_meas(ib), .vbus_ref(16'h8000), .ff_factor(16'hffff),
    .vin_uv_lim(uvl), .vin_ov_lim(ovl), .vbus_uv_lim(bul), .vbus_ov_lim(bol),
    .i_oc_lim(ocl), .kp_v(16'hffff), .kp_i(16'hffff), .run_en(run_en), .startup_fail(sfail),
    .fault_clear(fclr), .signal_crossbar_sel(sel), .drive_a(da_o), .drive_b(db_o), .adc_trig(trig),
    .reload_evt(rel), .periodic_tick_timer(tick), .fault_flags(flt), .duty_a(da), .duty_b(db));
  initial forever #5 core_clk = ~core_clk;
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask
  function logic pick(input int id);
    return id == 0 ? trig[0] : id == 1 ? trig[1] : id == 2 ? rel : tick;
  endfunction
  // cycles until the chosen pulse is seen, bounded
  task wait_sig(input int id, output int n);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (pick(id) !== 1'b1 && n < 5000);
    if (n >= 5000)
    begin
      miscompares++;
      test_done();
    end
  endtask
  task t_timing;
    int n;
    wait_sig(0, n);
    wait_sig(0, n);
    check(n, 1000, "trig a spacing");
    wait_sig(1, n);
    check(n, 500, "phase b offset");
    wait_sig(2, n);
    wait_sig(2, n);
    check(n, 2000, "reload spacing");
    wait_sig(3, n);
    wait_sig(3, n);
    check(n, 200, "tick spacing");
  endtask
  // pulse width per period must match 2*duty-1 with center alignment
  task t_duty;
    int n, ha, hb;
    ha = 0;
    hb = 0;
    wait_sig(1, n);
    for (int i = 0; i < 1000; i++)
    begin
      @(negedge core_clk);
      ha += int'(da_o === 1'b1);
      hb += int'(db_o === 1'b1);
    end
    check(32'(da <= PERIOD_TOP), 1, "duty a clamp");
    check(32'(db <= PERIOD_TOP), 1, "duty b clamp");
    check(ha, da == 0 ? 0 : 2 * da - 1, "drive a width");
    check(hb, db == 0 ? 0 : 2 * db - 1, "drive b width");
  endtask
  // one full period with sel 8'h0c, then 1100 cycles with all routes off: exactly one pulse per enabled route
  task t_signal_crossbar;
    int na, nb, nx;
    na = 0;
    nb = 0;
    nx = 0;
    sel = 8'h0c;
    repeat (1000)
    begin
      @(negedge core_clk);
      na += int'(trig === 8'h04);
      nb += int'(trig === 8'h08);
      nx += int'(trig !== 8'h00 && trig !== 8'h04 && trig !== 8'h08);
    end
    check(na, 1, "routed trigger a");
    check(nb, 1, "routed trigger b");
    check(nx, 0, "stray triggers");
    sel = 8'h00;
    nx = 0;
    repeat (1100) @(negedge core_clk) nx += int'(trig !== 8'h00);
    check(nx, 0, "masked triggers");
    sel = 8'h03;
  endtask
  task t_fault(input int bitn);
    int n;
    n = 0;
    repeat (20) @(negedge core_clk);
    check(flt[bitn], 1, "fault flag");
    repeat (1000) @(negedge core_clk) n += int'(da_o !== 1'b0 || db_o !== 1'b0);
    check(n, 0, "drives off in fault");
    {uvl, ovl, bul, bol, ocl, sfail, fclr} = {16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'hffff, 1'b0, 1'b1};
    repeat (10) @(negedge core_clk);
    fclr = 0;
    check(flt, 0, "fault cleared");
  endtask
  initial
  begin
    repeat (16) @(negedge core_clk);
    reset_n = 1;
    check({trig, rel, tick, flt, da_o, db_o}, 0, "reset outputs");
    run_en = 1;
    t_timing();
    repeat (6000) @(negedge core_clk);
    t_duty();
    t_signal_crossbar();
    uvl = 16'h5000;
    t_fault(FLT_IN_UV);
    ovl = 16'h3000;
    t_fault(FLT_IN_OV);
    bul = 16'h2000;
    t_fault(FLT_BUS_UV);
    bol = 16'h0800;
    t_fault(FLT_BUS_OV);
    ocl = 16'h0080;
    t_fault(FLT_OC);
    sfail = 1;
    t_fault(FLT_START);
    test_done();
  end
endmodule
